// ===== src/ccs_pkg.sv
// Shared constants and types of the common command and status unit
package ccs_pkg;
  typedef enum logic [4:0] {
    CMD_NONE, CMD_CLEAR_STATUS, CMD_EVENT_ENABLE, CMD_EVENT_READ,
    CMD_IDENTIFY, CMD_INDIV_STATUS, CMD_OP_COMPLETE, CMD_OPTIONS,
    CMD_POLL_ENABLE, CMD_RECALL, CMD_RESET, CMD_SAVE, CMD_SRQ_ENABLE,
    CMD_STATUS_BYTE, CMD_TRIGGER, CMD_SELFTEST, CMD_WAIT
  } cmd_t;
  typedef enum logic [1:0] {
    RSP_NUMBER, RSP_ID_STRING, RSP_OPTION_LIST
  } rsp_kind_t;
  localparam logic [7:0] HDR_MARK = 8'h2A;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Event status bits
  localparam int ESR_OPC_BIT = 0;
  localparam int ESR_QUERY_ERR_BIT = 2;
  localparam int ESR_EXEC_ERR_BIT = 4;
  localparam int ESR_CMD_ERR_BIT = 5;
  // Status byte bits
  localparam int STB_ERRQ_BIT = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  localparam int STB_OPER_BIT = 7;
  localparam int SETTINGS_W = 32;
  localparam int SLOT_COUNT = 10;
  localparam logic [15:0] SLOT_MAX = 16'h0009;
  localparam logic [15:0] REG_MAX = 16'h00FF;
  localparam logic [15:0] OPC_ANSWER = 16'h0001;
endpackage

// ===== src/ccs_header_decode.sv
// Common command header recogniser
`timescale 1ns/100ps
module ccs_header_decode (
  input wire logic [31:0] header,
  output ccs_pkg::cmd_t cmd,
  output logic form_ok
);
  function automatic logic is_letter(input logic [7:0] c);
    return (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A);
  endfunction
  function automatic logic [7:0] upper(input logic [7:0] c);
    return (c >= 8'h61) ? (c - 8'h20) : c;
  endfunction
  logic [23:0] word;
  always_comb begin
    form_ok = header[31:24] == ccs_pkg::HDR_MARK && is_letter(header[23:16])
      && is_letter(header[15:8]) && is_letter(header[7:0]);
    word = {upper(header[23:16]), upper(header[15:8]), upper(header[7:0])};
    cmd = ccs_pkg::CMD_NONE;
    if (form_ok) begin
      unique case (word)
        24'h434C53: cmd = ccs_pkg::CMD_CLEAR_STATUS;
        24'h455345: cmd = ccs_pkg::CMD_EVENT_ENABLE;
        24'h455352: cmd = ccs_pkg::CMD_EVENT_READ;
        24'h49444E: cmd = ccs_pkg::CMD_IDENTIFY;
        24'h495354: cmd = ccs_pkg::CMD_INDIV_STATUS;
        24'h4F5043: cmd = ccs_pkg::CMD_OP_COMPLETE;
        24'h4F5054: cmd = ccs_pkg::CMD_OPTIONS;
        24'h505245: cmd = ccs_pkg::CMD_POLL_ENABLE;
        24'h52434C: cmd = ccs_pkg::CMD_RECALL;
        24'h525354: cmd = ccs_pkg::CMD_RESET;
        24'h534156: cmd = ccs_pkg::CMD_SAVE;
        24'h535245: cmd = ccs_pkg::CMD_SRQ_ENABLE;
        24'h535442: cmd = ccs_pkg::CMD_STATUS_BYTE;
        24'h545247: cmd = ccs_pkg::CMD_TRIGGER;
        24'h545354: cmd = ccs_pkg::CMD_SELFTEST;
        24'h574149: cmd = ccs_pkg::CMD_WAIT;
        default: cmd = ccs_pkg::CMD_NONE;
      endcase
    end
  end
endmodule

// ===== src/ccs_state_store.sv
// Ten-slot store of complete device settings
`timescale 1ns/100ps
module ccs_state_store (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic save,
  input wire logic recall,
  input wire logic [3:0] slot,
  input wire logic [ccs_pkg::SETTINGS_W-1:0] settings_in,
  output logic [ccs_pkg::SETTINGS_W-1:0] settings_out,
  output logic settings_load
);
  typedef struct packed {
    logic [ccs_pkg::SLOT_COUNT-1:0][ccs_pkg::SETTINGS_W-1:0] mem;
    logic [ccs_pkg::SETTINGS_W-1:0] out;
    logic load;
  } store_t;
  store_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.load = 1'b0;
    if (save) begin
      s_d.mem[slot] = settings_in;
    end
    if (recall) begin
      s_d.out = s_q.mem[slot];
      s_d.load = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign settings_out = s_q.out;
  assign settings_load = s_q.load;
endmodule

// ===== src/ccs_unit.sv
// Common command interpreter with status, poll and save/recall handling
`timescale 1ns/100ps
// Operation
// - Headers are asterisk plus three letters
// - Clear status empties events and error queue
// - Clear status keeps enable and transition parts
// - Event enable register 0-255, reset zero
// - Event status read returns then clears
// - Completion command sets event bit 0
// - Completion query waits, then answers 1
// - Poll enable register 0-255, reset zero
// - Individual status query returns poll flag
// - Request enable register selects service requests
// - Status byte readable by query only
// - Save stores settings into slot 0-9
// - Recall restores settings from slot 0-9
// - Reset equals system preset
// - Trigger acts only when waiting on bus
// - Self-test query answers zero when passing
// - Wait blocks until done and settled
// - Asynchronous commands may overlap later ones
// - Identification reports firmware version too
// - Option query lists options, query only
// - Only basic units; none gives default; the unit rejects any given unit as a command error
// - Unmarked commands support setting and query; clear status, save, recall, reset, trigger, wait take no query
module ccs_unit #(
  // Arbitrary value, reported in the identification answer
  parameter logic [15:0] FW_VERSION = 16'h0100
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [31:0] cmd_header,
  input wire logic cmd_query,
  input wire logic cmd_has_param,
  input wire logic [15:0] cmd_param,
  input wire logic cmd_unit_given,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output ccs_pkg::rsp_kind_t rsp_kind,
  output logic [15:0] rsp_value,
  input wire logic [7:0] std_event_in,
  input wire logic ques_summary,
  input wire logic oper_summary,
  input wire logic err_queue_nonempty,
  output logic clear_event_parts,
  output logic clear_error_queue,
  input wire logic op_busy,
  input wire logic signals_settled,
  input wire logic sys_preset_req,
  output logic preset,
  input wire logic [ccs_pkg::SETTINGS_W-1:0] settings_in,
  output logic [ccs_pkg::SETTINGS_W-1:0] settings_out,
  output logic settings_load,
  input wire logic trig_waiting,
  input wire logic trig_source_bus,
  output logic trig_start,
  output logic selftest_start,
  input wire logic selftest_done,
  input wire logic [7:0] selftest_result,
  input wire logic [15:0] options_installed,
  output logic [7:0] status_byte,
  output logic srq,
  output logic ist
);
  typedef enum logic [1:0] {ST_IDLE, ST_BLOCK, ST_TEST, ST_ANSWER} state_t;
  typedef struct packed {
    state_t st;
    logic [7:0] ese;
    logic [7:0] esr;
    logic [7:0] ppe;
    logic [7:0] sre;
    // Completion command waits here until overlapped work drains
    logic opc_armed;
    logic blk_answer;
    ccs_pkg::rsp_kind_t kind;
    logic [15:0] value;
    logic clr_events;
    logic clr_errq;
    logic preset;
    logic trig;
    logic test_start;
    logic save;
    logic recall;
    logic [3:0] slot;
  } unit_t;

  unit_t u_q, u_d;
  ccs_pkg::cmd_t cmd;
  logic form_ok;
  logic [7:0] stb;
  logic ist_flag;
  logic accept;
  logic q_ok;
  logic s_ok;
  logic need_param;
  logic [7:0] errs;

  // Commands that may be sent as a query
  function automatic logic query_allowed(input ccs_pkg::cmd_t c);
    unique case (c)
      ccs_pkg::CMD_EVENT_ENABLE, ccs_pkg::CMD_EVENT_READ,
      ccs_pkg::CMD_IDENTIFY, ccs_pkg::CMD_INDIV_STATUS,
      ccs_pkg::CMD_OP_COMPLETE, ccs_pkg::CMD_OPTIONS,
      ccs_pkg::CMD_POLL_ENABLE, ccs_pkg::CMD_SRQ_ENABLE,
      ccs_pkg::CMD_STATUS_BYTE, ccs_pkg::CMD_SELFTEST: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Commands that may be sent as a setting or event
  function automatic logic setting_allowed(input ccs_pkg::cmd_t c);
    unique case (c)
      ccs_pkg::CMD_NONE, ccs_pkg::CMD_EVENT_READ,
      ccs_pkg::CMD_IDENTIFY, ccs_pkg::CMD_INDIV_STATUS,
      ccs_pkg::CMD_OPTIONS, ccs_pkg::CMD_STATUS_BYTE,
      ccs_pkg::CMD_SELFTEST: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction

  function automatic logic param_needed(input ccs_pkg::cmd_t c);
    unique case (c)
      ccs_pkg::CMD_EVENT_ENABLE, ccs_pkg::CMD_POLL_ENABLE,
      ccs_pkg::CMD_SRQ_ENABLE, ccs_pkg::CMD_RECALL,
      ccs_pkg::CMD_SAVE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  ccs_header_decode decode (
    .header(cmd_header),
    .cmd(cmd),
    .form_ok(form_ok)
  );

  // Save and recall reach the store one cycle after the command is taken
  ccs_state_store store (
    .clk(clk),
    .reset_n(reset_n),
    .save(u_q.save),
    .recall(u_q.recall),
    .slot(u_q.slot),
    .settings_in(settings_in),
    .settings_out(settings_out),
    .settings_load(settings_load)
  );

  // Status byte is derived, so clearing its sources clears it
  always_comb begin
    stb = 8'h00;
    stb[ccs_pkg::STB_ERRQ_BIT] = err_queue_nonempty;
    stb[ccs_pkg::STB_QUES_BIT] = ques_summary;
    stb[ccs_pkg::STB_MAV_BIT] = u_q.st == ST_ANSWER;
    stb[ccs_pkg::STB_ESB_BIT] = |(u_q.esr & u_q.ese);
    stb[ccs_pkg::STB_OPER_BIT] = oper_summary;
    stb[ccs_pkg::STB_MSS_BIT] = |(stb & u_q.sre);
    ist_flag = |(stb & u_q.ppe);
  end

  assign cmd_ready = u_q.st == ST_IDLE;
  assign accept = cmd_valid && cmd_ready;
  assign q_ok = query_allowed(cmd);
  assign s_ok = setting_allowed(cmd);
  assign need_param = param_needed(cmd);

  always_comb begin
    u_d = u_q;
    u_d.clr_events = 1'b0;
    u_d.clr_errq = 1'b0;
    u_d.preset = sys_preset_req;
    u_d.trig = 1'b0;
    u_d.test_start = 1'b0;
    u_d.save = 1'b0;
    u_d.recall = 1'b0;
    errs = std_event_in;
    // Completion bit waits for overlapped work started earlier
    if (u_q.opc_armed && !op_busy) begin
      errs[ccs_pkg::ESR_OPC_BIT] = 1'b1;
      u_d.opc_armed = 1'b0;
    end
    unique case (u_q.st)
      ST_IDLE: begin
        if (accept) begin
          if (!form_ok || cmd == ccs_pkg::CMD_NONE || cmd_unit_given) begin
            // Common commands carry no unit at all
            errs[ccs_pkg::ESR_CMD_ERR_BIT] = 1'b1;
          end else if (cmd_query && !q_ok) begin
            errs[ccs_pkg::ESR_CMD_ERR_BIT] = 1'b1;
          end else if (!cmd_query && (!s_ok || (need_param && !cmd_has_param))) begin
            errs[ccs_pkg::ESR_CMD_ERR_BIT] = 1'b1;
          end else if (!cmd_query && need_param && cmd_param > ccs_pkg::REG_MAX) begin
            errs[ccs_pkg::ESR_EXEC_ERR_BIT] = 1'b1;
          end else begin
            u_d.kind = ccs_pkg::RSP_NUMBER;
            u_d.value = 16'h0000;
            if (cmd_query) begin
              u_d.st = ST_ANSWER;
            end
            unique case (cmd)
              ccs_pkg::CMD_CLEAR_STATUS: begin
                // Enable masks are left alone on purpose
                u_d.esr = 8'h00;
                u_d.opc_armed = 1'b0;
                u_d.clr_events = 1'b1;
                u_d.clr_errq = 1'b1;
              end
              ccs_pkg::CMD_EVENT_ENABLE: begin
                if (cmd_query) begin
                  u_d.value = {8'h00, u_q.ese};
                end else begin
                  u_d.ese = cmd_param[7:0];
                end
              end
              ccs_pkg::CMD_EVENT_READ: begin
                u_d.value = {8'h00, u_q.esr};
                u_d.esr = 8'h00;
              end
              ccs_pkg::CMD_IDENTIFY: begin
                u_d.kind = ccs_pkg::RSP_ID_STRING;
                u_d.value = FW_VERSION;
              end
              ccs_pkg::CMD_INDIV_STATUS: begin
                u_d.value = {15'h0000, ist_flag};
              end
              ccs_pkg::CMD_OP_COMPLETE: begin
                if (cmd_query) begin
                  u_d.st = ST_BLOCK;
                  u_d.blk_answer = 1'b1;
                end else begin
                  u_d.opc_armed = 1'b1;
                end
              end
              ccs_pkg::CMD_OPTIONS: begin
                u_d.kind = ccs_pkg::RSP_OPTION_LIST;
                u_d.value = options_installed;
              end
              ccs_pkg::CMD_POLL_ENABLE: begin
                if (cmd_query) begin
                  u_d.value = {8'h00, u_q.ppe};
                end else begin
                  u_d.ppe = cmd_param[7:0];
                end
              end
              ccs_pkg::CMD_SRQ_ENABLE: begin
                if (cmd_query) begin
                  u_d.value = {8'h00, u_q.sre};
                end else begin
                  u_d.sre = cmd_param[7:0];
                end
              end
              ccs_pkg::CMD_RECALL, ccs_pkg::CMD_SAVE: begin
                if (cmd_param > ccs_pkg::SLOT_MAX) begin
                  errs[ccs_pkg::ESR_EXEC_ERR_BIT] = 1'b1;
                end else begin
                  u_d.slot = cmd_param[3:0];
                  u_d.save = cmd == ccs_pkg::CMD_SAVE;
                  u_d.recall = cmd == ccs_pkg::CMD_RECALL;
                end
              end
              ccs_pkg::CMD_RESET: begin
                u_d.preset = 1'b1;
              end
              ccs_pkg::CMD_STATUS_BYTE: begin
                u_d.value = {8'h00, stb};
              end
              ccs_pkg::CMD_TRIGGER: begin
                u_d.trig = trig_waiting && trig_source_bus;
              end
              ccs_pkg::CMD_SELFTEST: begin
                u_d.test_start = 1'b1;
                u_d.st = ST_TEST;
              end
              ccs_pkg::CMD_WAIT: begin
                u_d.st = ST_BLOCK;
                u_d.blk_answer = 1'b0;
              end
              default: begin
                u_d.st = ST_IDLE;
              end
            endcase
          end
        end
      end
      ST_BLOCK: begin
        // Overlapped commands are waited for here and by the armed completion bit
        if (!op_busy && signals_settled) begin
          if (u_q.blk_answer) begin
            u_d.value = ccs_pkg::OPC_ANSWER;
            u_d.st = ST_ANSWER;
          end else begin
            u_d.st = ST_IDLE;
          end
        end
      end
      ST_TEST: begin
        // No timeout: a back end that never finishes holds the unit here
        if (selftest_done) begin
          u_d.value = {8'h00, selftest_result};
          u_d.st = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        // Message-available bit follows this state until the answer is taken
        if (rsp_ready) begin
          u_d.st = ST_IDLE;
        end
      end
    endcase
    // New events win over a clear in the same cycle
    u_d.esr = u_d.esr | errs;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      u_q <= '0;
      u_q.st <= ST_IDLE;
      // Enables come up zero, so no service request can follow reset
      u_q.ese <= ccs_pkg::REG_RESET;
      u_q.ppe <= ccs_pkg::REG_RESET;
      u_q.sre <= ccs_pkg::REG_RESET;
      u_q.kind <= ccs_pkg::RSP_NUMBER;
    end else begin
      u_q <= u_d;
    end
  end

  assign rsp_valid = u_q.st == ST_ANSWER;
  assign rsp_kind = u_q.kind;
  assign rsp_value = u_q.value;
  assign clear_event_parts = u_q.clr_events;
  assign clear_error_queue = u_q.clr_errq;
  assign preset = u_q.preset;
  assign trig_start = u_q.trig;
  assign selftest_start = u_q.test_start;
  assign status_byte = stb;
  assign srq = stb[ccs_pkg::STB_MSS_BIT];
  assign ist = ist_flag;
endmodule

// ===== sim/ccs_backend_model.sv
// Model of the measurement back end: overlapped work and self-test
`timescale 1ns/100ps
module ccs_backend_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic selftest_start,
  input wire logic [7:0] fault_code,
  output logic op_busy,
  output logic signals_settled,
  output logic selftest_done,
  output logic [7:0] selftest_result
);
  logic [4:0] busy_q;
  logic [2:0] tst_q;
  // Work keeps running while later commands are taken
  assign op_busy = busy_q != 5'h00;
  assign signals_settled = !op_busy;
  assign selftest_done = tst_q == 3'h1;
  // Result is only valid with done; garbage otherwise
  assign selftest_result = selftest_done ? fault_code : ~fault_code;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 5'h00;
      tst_q <= 3'h0;
    end else begin
      busy_q <= go ? 5'h14 : busy_q - {4'h0, op_busy};
      tst_q <= selftest_start ? 3'h5 : tst_q - {2'h0, tst_q != 3'h0};
    end
  end
endmodule

// ===== sim/ccs_unit_chk.sv
// Port checker for the common command and status unit
`timescale 1ns/100ps
module ccs_unit_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [31:0] cmd_header,
  input wire logic cmd_query,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input ccs_pkg::rsp_kind_t rsp_kind,
  input wire logic [15:0] rsp_value,
  input wire logic ques_summary,
  input wire logic oper_summary,
  input wire logic err_queue_nonempty,
  input wire logic clear_event_parts,
  input wire logic clear_error_queue,
  input wire logic op_busy,
  input wire logic signals_settled,
  input wire logic sys_preset_req,
  input wire logic preset,
  input wire logic settings_load,
  input wire logic trig_waiting,
  input wire logic trig_source_bus,
  input wire logic trig_start,
  input wire logic selftest_start,
  input wire logic [7:0] status_byte
);
  localparam logic [31:0] WAIT_HDR = 32'h2A574149;
  localparam logic [31:0] DONE_HDR = 32'h2A4F5043;
  localparam logic [31:0] TEST_HDR = 32'h2A545354;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_take(logic [31:0] h, logic q);
    cmd_valid && cmd_ready && cmd_header == h && cmd_query == q;
  endsequence
  sequence s_idle2;
    (!op_busy && signals_settled) [*2];
  endsequence
  a_rsp_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid &&
    $stable(rsp_value) && $stable(rsp_kind)) else $error("answer changed before taken");
  a_stb_levels: assert property (status_byte[3] == ques_summary &&
    status_byte[7] == oper_summary && status_byte[2] == err_queue_nonempty)
    else $error("status byte summary bits wrong");
  a_preset_follows: assert property (sys_preset_req |=> preset)
    else $error("preset did not follow request");
  a_trig_gated: assert property (trig_start |-> $past(trig_waiting && trig_source_bus))
    else $error("trigger started without bus wait");
  a_clear_pair: assert property (clear_event_parts |-> clear_error_queue ##1
    !clear_event_parts) else $error("clear pulses wrong");
  a_wait_blocks: assert property (s_take(WAIT_HDR, 1'b0) ##1 op_busy |-> !cmd_ready)
    else $error("command taken while waiting");
  a_opc_waits: assert property (s_take(DONE_HDR, 1'b1) ##0 op_busy ##1 op_busy [*2]
    |-> !rsp_valid) else $error("completion answered while busy");
  a_opc_answer: assert property (s_take(DONE_HDR, 1'b1) ##1 s_idle2 |->
    ##[0:2] rsp_valid && rsp_value == 16'h0001) else $error("completion answer wrong");
  a_test_start: assert property (s_take(TEST_HDR, 1'b1) |-> ##[1:2] selftest_start)
    else $error("self-test not started");
  a_load_pulse: assert property (settings_load |=> !settings_load)
    else $error("load longer than one cycle");
endmodule
bind ccs_unit ccs_unit_chk i_chk (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_header(cmd_header), .cmd_query(cmd_query),
  .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_kind(rsp_kind), .rsp_value(rsp_value),
  .ques_summary(ques_summary), .oper_summary(oper_summary),
  .err_queue_nonempty(err_queue_nonempty), .clear_event_parts(clear_event_parts),
  .clear_error_queue(clear_error_queue), .op_busy(op_busy),
  .signals_settled(signals_settled), .sys_preset_req(sys_preset_req), .preset(preset),
  .settings_load(settings_load), .trig_waiting(trig_waiting),
  .trig_source_bus(trig_source_bus), .trig_start(trig_start),
  .selftest_start(selftest_start), .status_byte(status_byte));

// ===== sim/tb_top.sv
// Self-checking bench for the common command and status unit
`timescale 1ns/100ps
module tb_top;
  // Headers as ASCII: asterisk then three letters
  localparam logic [31:0] H_CLS = 32'h2A434C53, H_ESE = 32'h2A455345, H_ESR = 32'h2A455352;
  localparam logic [31:0] H_IDN = 32'h2A49444E, H_IST = 32'h2A495354, H_OPC = 32'h2A4F5043;
  localparam logic [31:0] H_OPT = 32'h2A4F5054, H_PRE = 32'h2A505245, H_RCL = 32'h2A52434C;
  localparam logic [31:0] H_RST = 32'h2A525354, H_SAV = 32'h2A534156, H_SRE = 32'h2A535245;
  localparam logic [31:0] H_STB = 32'h2A535442, H_TRG = 32'h2A545247, H_TST = 32'h2A545354;
  localparam logic [31:0] H_WAI = 32'h2A574149;
  logic clk, reset_n, cmd_valid, cmd_ready, cmd_query, cmd_has_param, cmd_unit_given;
  logic rsp_valid, rsp_ready, ques_summary, oper_summary, err_queue_nonempty;
  logic clear_event_parts, clear_error_queue, op_busy, signals_settled, sys_preset_req;
  logic preset, settings_load, trig_waiting, trig_source_bus, trig_start, selftest_start;
  logic selftest_done, srq, ist, go;
  logic [31:0] cmd_header, settings_in, settings_out;
  logic [15:0] cmd_param, rsp_value, options_installed, v;
  logic [7:0] std_event_in, selftest_result, status_byte, fault_code;
  ccs_pkg::rsp_kind_t rsp_kind, k;
  int miscompares = 0, checks_done = 0, cycles = 0, n_pre = 0, n_trig = 0, n_clr = 0, n_ld = 0;
  ccs_unit i_dut (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_header(cmd_header), .cmd_query(cmd_query), .cmd_has_param(cmd_has_param),
    .cmd_param(cmd_param), .cmd_unit_given(cmd_unit_given), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_kind(rsp_kind), .rsp_value(rsp_value),
    .std_event_in(std_event_in), .ques_summary(ques_summary), .oper_summary(oper_summary),
    .err_queue_nonempty(err_queue_nonempty), .clear_event_parts(clear_event_parts),
    .clear_error_queue(clear_error_queue), .op_busy(op_busy),
    .signals_settled(signals_settled), .sys_preset_req(sys_preset_req), .preset(preset),
    .settings_in(settings_in), .settings_out(settings_out), .settings_load(settings_load),
    .trig_waiting(trig_waiting), .trig_source_bus(trig_source_bus), .trig_start(trig_start),
    .selftest_start(selftest_start), .selftest_done(selftest_done),
    .selftest_result(selftest_result), .options_installed(options_installed),
    .status_byte(status_byte), .srq(srq), .ist(ist));
  ccs_backend_model i_back (.clk(clk), .reset_n(reset_n), .go(go),
    .selftest_start(selftest_start), .fault_code(fault_code), .op_busy(op_busy),
    .signals_settled(signals_settled), .selftest_done(selftest_done),
    .selftest_result(selftest_result));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Pulse counts taken mid-cycle, where outputs are settled, so a pulse counts once
  always @(negedge clk) begin
    cycles++;
    n_pre += preset;
    n_trig += trig_start;
    n_clr += clear_event_parts;
    n_ld += settings_load;
    if (cycles == 4000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Called at a falling edge; holds the request until the edge that takes it
  task automatic send(input logic [31:0] h, input logic q, hp, input logic [15:0] p,
                      input logic u);
    int n;
    cmd_valid = 1;
    cmd_header = h;
    cmd_query = q;
    cmd_has_param = hp;
    cmd_param = p;
    cmd_unit_given = u;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) miscompares++;
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 0;
    cmd_header = ~h;
    cmd_param = ~p;
    // Let an edge pass with valid low before the next request
    @(negedge clk);
  endtask
  task automatic put(input logic [31:0] h, input logic [15:0] p);
    send(h, 0, 1, p, 0);
  endtask
  task automatic ask(input logic [31:0] h, output logic [15:0] r);
    int n;
    send(h, 1, 0, 16'h0000, 0);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) miscompares++;
    r = rsp_value;
    k = rsp_kind;
    rsp_ready = 1;
    @(posedge clk);
    @(negedge clk);
    rsp_ready = 0;
  endtask
  task automatic pulse_go();
    go = 1;
    @(negedge clk);
    go = 0;
  endtask
  initial begin
    {reset_n, cmd_valid, cmd_query, cmd_has_param, cmd_unit_given, rsp_ready, go} = 0;
    {ques_summary, oper_summary, err_queue_nonempty, sys_preset_req} = 0;
    {trig_waiting, trig_source_bus} = 0;
    cmd_header = 0;
    cmd_param = 0;
    std_event_in = 0;
    settings_in = 0;
    options_installed = 0;
    fault_code = 0;
    repeat (5) @(negedge clk);
    reset_n = 1;
    @(negedge clk);
    ask(H_ESE, v); chk("ese reset", v, 0);
    ask(H_PRE, v); chk("pre reset", v, 0);
    ask(H_SRE, v); chk("sre reset", v, 0);
    put(H_ESE, 16'h00FF);
    put(H_PRE, 16'h0020);
    put(H_SRE, 16'h0020);
    put(H_ESE, 16'h0100);
    ask(H_ESE, v); chk("ese max kept", v, 16'h00FF);
    ask(H_PRE, v); chk("pre readback", v, 16'h0020);
    ask(H_IST, v); chk("ist flag", v, 16'h0001);
    ques_summary = 1;
    ask(H_STB, v); chk("stb bits", v & 16'h00EC, 16'h0068);
    chk("srq pin", srq, 1);
    chk("ist pin", ist, 1);
    ques_summary = 0;
    ask(H_ESR, v); chk("esr range err", v, 16'h0010);
    ask(H_ESR, v); chk("esr cleared", v, 0);
    send(32'h23455345, 1, 0, 0, 0);
    send(H_SAV, 1, 1, 0, 0);
    send(H_ESE, 0, 1, 16'h0001, 1);
    repeat (3) @(negedge clk);
    chk("no answer", rsp_valid, 0);
    ask(H_ESR, v); chk("esr cmd err", v, 16'h0020);
    std_event_in = 8'h80;
    @(negedge clk);
    std_event_in = 0;
    send(H_CLS, 0, 0, 0, 0);
    repeat (2) @(negedge clk);
    chk("clear pulses", n_clr, 1);
    ask(H_ESR, v); chk("esr after clear", v, 0);
    ask(H_ESE, v); chk("ese kept", v, 16'h00FF);
    pulse_go();
    send(H_OPC, 0, 0, 0, 0);
    ask(H_ESR, v); chk("opc while busy", v, 0);
    repeat (25) @(negedge clk);
    ask(H_ESR, v); chk("opc done", v, 16'h0001);
    pulse_go();
    ask(H_OPC, v); chk("opc answer", v, 16'h0001);
    chk("opc after idle", op_busy, 0);
    ask(H_OPC, v); chk("opc idle answer", v, 16'h0001);
    pulse_go();
    send(H_WAI, 0, 0, 0, 0);
    ask(H_ESE, v); chk("held by wait", op_busy, 0);
    settings_in = 32'hA5A50009;
    put(H_SAV, 16'h0009);
    settings_in = 32'h12345678;
    put(H_SAV, 16'h0000);
    settings_in = 0;
    put(H_RCL, 16'h0009);
    repeat (3) @(negedge clk);
    chk("recall slot 9", settings_out, 32'hA5A50009);
    put(H_RCL, 16'h0000);
    repeat (3) @(negedge clk);
    chk("recall slot 0", settings_out, 32'h12345678);
    chk("load pulses", n_ld, 2);
    put(H_RCL, 16'h000A);
    ask(H_ESR, v); chk("slot range", v, 16'h0010);
    send(H_RST, 0, 0, 0, 0);
    sys_preset_req = 1;
    @(negedge clk);
    sys_preset_req = 0;
    repeat (3) @(negedge clk);
    chk("presets", n_pre, 2);
    for (int i = 0; i < 4; i++) begin
      {trig_waiting, trig_source_bus} = i[1:0];
      repeat (2) @(negedge clk);
      send(H_TRG, 0, 0, 0, 0);
      repeat (3) @(negedge clk);
      chk("trigger count", n_trig, i / 3);
    end
    ask(H_TST, v); chk("selftest pass", v, 0);
    fault_code = 8'h05;
    ask(H_TST, v); chk("selftest fail", v, 16'h0005);
    ask(H_IDN, v); chk("id version", v, 16'h0100);
    chk("id kind", k, ccs_pkg::RSP_ID_STRING);
    options_installed = 16'h0005;
    ask(H_OPT, v); chk("options", v, 16'h0005);
    chk("options kind", k, ccs_pkg::RSP_OPTION_LIST);
    summarize();
  end
endmodule
